// file: hw/zrx_core.sv
`timescale 1ns/1ns
// What this block does
// - Read opcode 02; zone bits 1:0 select zone, 2-6 zero, bit 7 long.
// - Masked read XORs each fetched word with the matching digest word.
// - Masking never applies to configuration or fuse zones.
// - Address counts words; long reads ignore the three lowest bits.
// - Reads past the end of the zone give an error.
// - Data zone reads fail while unlocked; slot policy rules afterwards.
// - Four-byte read of a hidden slot gives an error.
// - Hidden slot without masked-read flag can never be read.
// - Slot with both flags clear reads unmasked, short or long.
// - Masked read needs valid, merged, matching source slot, random origin.
// - Config words always readable except permanently hidden words.
// - Fuse zone reads fail while fuse zone unlocked.
// - Locked fuse zone with non-zero policy hides words zero and one.
// - Compatibility fuse policy allows only four-byte fuse reads.
// - Update command changes spare bytes after setup lock.
// - Update opcode 20; mode bit 0 picks byte; operand high byte zero.
// - Spare user byte written only when currently zero, else error.
// - With pick check on, pick byte written only while zero.
// - With pick check off, pick byte overwritten whenever setup is locked, success.
// - Update returns 00 when the byte changed, else execution error.
module zrx_core (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  // Command in
  input wire logic I_CMD_VALID,
  input wire zrx_pkg::zrx_cmd_type I_CMD,
  output logic O_CMD_READY,
  // Response out
  output logic O_RSP_VALID,
  output zrx_pkg::zrx_rsp_type O_RSP,
  // Lock and policy state
  input wire logic I_SETUP_LOCKED,
  input wire logic I_FUSE_LOCKED,
  input wire logic I_DATA_LOCKED,
  input wire logic [7:0] I_FUSE_AREA_POLICY,
  input wire logic [15:0][15:0] I_SLOT_POLICY_WORD,
  input wire zrx_pkg::zrx_digest_type I_SCRATCH_DIGEST_REG,
  // Spare configuration bytes
  input wire logic [7:0] I_SPARE_USER_BYTE,
  input wire logic [7:0] I_PICK_BYTE,
  input wire logic [7:0] I_PICK_CHECK_ENABLE,
  // Storage read port
  output logic O_MEM_RD,
  output logic [1:0] O_MEM_ZONE,
  output logic [7:0] O_MEM_ADDR,
  input wire logic I_MEM_VLD,
  input wire logic [31:0] I_MEM_DATA,
  // Spare byte write port
  output logic O_CFG_WR,
  output logic O_CFG_WR_PICK,
  output logic [7:0] O_CFG_WR_DATA
);

  localparam logic [16:0] CFG_WORDS_I = zrx_pkg::CFG_WORDS;

  function automatic logic cfg_hidden(input logic [15:0] first, input logic [3:0] cnt);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < cnt && (32'(first) + 32'(k)) < 32'(CFG_WORDS_I)) begin
        hit = hit | zrx_pkg::CFG_HIDDEN_WORDS[5'(32'(first) + 32'(k))];
      end
    end
    return hit;
  endfunction : cfg_hidden

  zrx_pkg::zrx_state_type st_q, st_d;
  zrx_pkg::zrx_cmd_type cmd_q, cmd_d;
  zrx_pkg::zrx_rsp_type rsp_q, rsp_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] addr_q, addr_d;
  logic mask_q, mask_d;
  logic wr_q, wr_d;
  logic wr_pick_q, wr_pick_d;
  logic [7:0] wr_data_q, wr_data_d;

  // Decode of the held command
  logic is_read, is_upd, long_rd, parse_err, read_err, range_err, zone_err, upd_pick;
  logic [1:0] zone;
  logic [15:0] word_addr;
  logic [3:0] nwords;
  logic [16:0] zone_words;
  logic [15:0] policy;
  logic hidden, masked, digest_ok;
  zrx_pkg::zrx_digest_type dig;

  assign dig = I_SCRATCH_DIGEST_REG;
  assign is_read = cmd_q.opcode == zrx_pkg::OP_READ;
  assign is_upd = cmd_q.opcode == zrx_pkg::OP_UPDATE;
  assign zone = cmd_q.param1[1:0];
  assign long_rd = cmd_q.param1[zrx_pkg::ZONE_LONG_BIT];
  assign upd_pick = cmd_q.param1[zrx_pkg::UPD_SEL_BIT];
  // Long reads drop the word-in-block bits
  assign word_addr = long_rd ? (cmd_q.param2 & zrx_pkg::BLOCK_ALIGN_MASK) : cmd_q.param2;
  assign nwords = long_rd ? zrx_pkg::BLOCK_WORDS : 4'h1;
  assign policy = I_SLOT_POLICY_WORD[word_addr[zrx_pkg::SLOT_LO +: 4]];
  assign hidden = policy[zrx_pkg::POL_HIDDEN_BIT];
  assign masked = policy[zrx_pkg::POL_MASK_BIT];

  always_comb begin
    parse_err = 1'b0;
    if (is_read) begin
      parse_err = ((cmd_q.param1 & zrx_pkg::RD_MBZ_MASK) != 8'h00) || zone == 2'h3;
    end else if (is_upd) begin
      parse_err = ((cmd_q.param1 & zrx_pkg::UPD_MBZ_MASK) != 8'h00) ||
                  ((cmd_q.param2 & zrx_pkg::UPD_P2_MBZ_MASK) != 16'h0000);
    end else begin
      parse_err = 1'b1;
    end
  end

  always_comb begin
    zone_words = zrx_pkg::CFG_WORDS;
    if (zone == zrx_pkg::ZONE_FUSE) begin
      zone_words = zrx_pkg::FUSE_WORDS;
    end else if (zone == zrx_pkg::ZONE_DATA) begin
      zone_words = zrx_pkg::DATA_WORDS;
    end
  end

  assign range_err = ({1'b0, word_addr} + {13'h0000, nwords}) > zone_words;
  // Key source must be a random-nonce merge with this slot's read key
  assign digest_ok = dig.valid && dig.merged && dig.origin_rand &&
                     dig.source_slot == policy[zrx_pkg::POL_KEY_LO +: 4];

  always_comb begin
    zone_err = 1'b0;
    if (zone == zrx_pkg::ZONE_CFG) begin
      zone_err = cfg_hidden(word_addr, nwords);
    end else if (zone == zrx_pkg::ZONE_FUSE) begin
      zone_err = !I_FUSE_LOCKED ||
                 (I_FUSE_AREA_POLICY != 8'h00 && word_addr < zrx_pkg::FUSE_GUARD_WORDS) ||
                 (I_FUSE_AREA_POLICY == zrx_pkg::FUSE_LEGACY && long_rd);
    end else begin
      zone_err = !I_DATA_LOCKED ||
                 (hidden && !long_rd) ||
                 (hidden && !masked) ||
                 (masked && !digest_ok);
    end
  end

  assign read_err = range_err || zone_err;

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    rsp_d = rsp_q;
    idx_d = idx_q;
    addr_d = addr_q;
    mask_d = mask_q;
    wr_d = 1'b0;
    wr_pick_d = wr_pick_q;
    wr_data_d = wr_data_q;
    case (st_q)
      zrx_pkg::ST_IDLE: begin
        if (I_CMD_VALID) begin
          cmd_d = I_CMD;
          st_d = zrx_pkg::ST_CHECK;
        end
      end
      zrx_pkg::ST_CHECK: begin
        rsp_d = '0;
        rsp_d.status = zrx_pkg::STS_EXEC;
        st_d = zrx_pkg::ST_RESP;
        if (parse_err) begin
          rsp_d.status = zrx_pkg::STS_PARSE;
        end else if (is_upd) begin
          wr_pick_d = upd_pick;
          wr_data_d = cmd_q.param2[7:0];
          // Refused before setup lock so spare bytes stay under setup control
          if (!I_SETUP_LOCKED) begin
            rsp_d.status = zrx_pkg::STS_EXEC;
          end else if (!upd_pick) begin
            if (I_SPARE_USER_BYTE == 8'h00) begin
              wr_d = 1'b1;
            end
          end else if (I_PICK_CHECK_ENABLE == 8'h00 || I_PICK_BYTE == 8'h00) begin
            wr_d = 1'b1;
          end
          if (wr_d) begin
            rsp_d.status = zrx_pkg::STS_OK;
          end
        end else if (!read_err) begin
          // Masking is decided by the slot flag in data zone only
          mask_d = zone == zrx_pkg::ZONE_DATA && masked;
          idx_d = 3'h0;
          addr_d = word_addr[7:0];
          rsp_d.long_read = long_rd;
          st_d = zrx_pkg::ST_FETCH;
        end
      end
      zrx_pkg::ST_FETCH: begin
        st_d = zrx_pkg::ST_WAIT;
      end
      zrx_pkg::ST_WAIT: begin
        if (I_MEM_VLD) begin
          rsp_d.data[idx_q] = mask_q ? (I_MEM_DATA ^ dig.value[idx_q]) : I_MEM_DATA;
          if ({1'b0, idx_q} == nwords - 4'h1) begin
            rsp_d.status = zrx_pkg::STS_OK;
            rsp_d.has_data = 1'b1;
            st_d = zrx_pkg::ST_RESP;
          end else begin
            idx_d = idx_q + 3'h1;
            addr_d = addr_q + 8'h01;
            st_d = zrx_pkg::ST_FETCH;
          end
        end
      end
      zrx_pkg::ST_RESP: begin
        mask_d = 1'b0;
        st_d = zrx_pkg::ST_IDLE;
      end
      default: begin
        st_d = zrx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_q <= zrx_pkg::ST_IDLE;
      cmd_q <= '0;
      rsp_q <= '0;
      idx_q <= 3'h0;
      addr_q <= 8'h00;
      mask_q <= 1'b0;
      wr_q <= 1'b0;
      wr_pick_q <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      rsp_q <= rsp_d;
      idx_q <= idx_d;
      addr_q <= addr_d;
      mask_q <= mask_d;
      wr_q <= wr_d;
      wr_pick_q <= wr_pick_d;
      wr_data_q <= wr_data_d;
    end
  end

  assign O_CMD_READY = st_q == zrx_pkg::ST_IDLE;
  assign O_RSP_VALID = st_q == zrx_pkg::ST_RESP;
  assign O_RSP = rsp_q;
  assign O_MEM_RD = st_q == zrx_pkg::ST_FETCH;
  assign O_MEM_ZONE = cmd_q.param1[1:0];
  assign O_MEM_ADDR = addr_q;
  assign O_CFG_WR = wr_q;
  assign O_CFG_WR_PICK = wr_pick_q;
  assign O_CFG_WR_DATA = wr_data_q;

  // Checks on the held command as it is judged, on masking and on fetch timing
  logic in_check;
  assign in_check = st_q == zrx_pkg::ST_CHECK;

  parse_mbz_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && (cmd_q.param1 & zrx_pkg::RD_MBZ_MASK) != 8'h00
    |=> O_RSP_VALID && O_RSP.status == zrx_pkg::STS_PARSE)
    else $error("read with must-be-zero bits not refused");

  range_end_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && range_err |=> O_RSP_VALID && O_RSP.status != zrx_pkg::STS_OK)
    else $error("out of range read not refused");

  data_lock_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && zone == zrx_pkg::ZONE_DATA && !I_DATA_LOCKED
    |=> O_RSP_VALID && !O_RSP.has_data)
    else $error("data zone read while unlocked");

  short_hidden_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && zone == zrx_pkg::ZONE_DATA && hidden && !long_rd
    |=> ##0 st_q == zrx_pkg::ST_RESP ##1 !$past(O_RSP.has_data))
    else $error("short read of hidden slot allowed");

  never_read_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && zone == zrx_pkg::ZONE_DATA && hidden && !masked
    |=> !O_MEM_RD)
    else $error("hidden unmasked slot fetched");

  digest_gate_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && !parse_err && zone == zrx_pkg::ZONE_DATA && masked && !digest_ok
    |=> O_RSP_VALID && O_RSP.status == zrx_pkg::STS_EXEC)
    else $error("masked read with unusable digest");

  mask_zone_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    mask_q |-> cmd_q.param1[1:0] == zrx_pkg::ZONE_DATA)
    else $error("masking outside data zone");

  fuse_guard_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_read && zone == zrx_pkg::ZONE_FUSE &&
    (!I_FUSE_LOCKED || (I_FUSE_AREA_POLICY != 8'h00 && word_addr < zrx_pkg::FUSE_GUARD_WORDS))
    |=> O_RSP_VALID && O_RSP.status != zrx_pkg::STS_OK)
    else $error("guarded fuse word returned");

  spare_once_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_upd && !parse_err && !upd_pick && I_SPARE_USER_BYTE != 8'h00
    |=> !O_CFG_WR && O_RSP.status == zrx_pkg::STS_EXEC)
    else $error("non-zero spare byte overwritten");

  pick_free_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    in_check && is_upd && !parse_err && I_SETUP_LOCKED && upd_pick &&
    I_PICK_CHECK_ENABLE == 8'h00
    |=> O_CFG_WR && O_CFG_WR_PICK && O_RSP.status == zrx_pkg::STS_OK)
    else $error("unchecked pick byte not written");

  fetch_wait_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    O_MEM_RD |=> st_q == zrx_pkg::ST_WAIT && $stable(O_MEM_ADDR))
    else $error("fetch did not wait for storage");
endmodule : zrx_core

// file: inc/zrx_pkg.sv
package zrx_pkg;
  // Opcodes and parameter masks
  localparam logic [7:0] OP_READ = 8'h02;
  localparam logic [7:0] OP_UPDATE = 8'h20;
  localparam logic [7:0] RD_MBZ_MASK = 8'h7C;
  localparam logic [7:0] UPD_MBZ_MASK = 8'hFE;
  localparam logic [15:0] UPD_P2_MBZ_MASK = 16'hFF00;
  localparam int ZONE_LONG_BIT = 7;
  localparam int UPD_SEL_BIT = 0;

  // Zone selectors
  localparam logic [1:0] ZONE_CFG = 2'h0;
  localparam logic [1:0] ZONE_FUSE = 2'h1;
  localparam logic [1:0] ZONE_DATA = 2'h2;

  // Zone sizes in 4-byte words
  localparam logic [16:0] CFG_WORDS = 17'h00016;
  localparam logic [16:0] FUSE_WORDS = 17'h00010;
  localparam logic [16:0] DATA_WORDS = 17'h00080;
  localparam logic [3:0] BLOCK_WORDS = 4'h8;
  localparam logic [15:0] BLOCK_ALIGN_MASK = 16'hFFF8;
  localparam logic [15:0] FUSE_GUARD_WORDS = 16'h0002;
  localparam int SLOT_LO = 3;

  // Config words that can never be read out
  localparam logic [21:0] CFG_HIDDEN_WORDS = 22'h000000;

  // Fuse-area policy value for compatibility mode
  localparam logic [7:0] FUSE_LEGACY = 8'hAA;

  // Slot policy word fields
  localparam int POL_HIDDEN_BIT = 7;
  localparam int POL_MASK_BIT = 6;
  localparam int POL_KEY_LO = 0;

  // Status codes
  localparam logic [7:0] STS_OK = 8'h00;
  localparam logic [7:0] STS_PARSE = 8'h03;
  localparam logic [7:0] STS_EXEC = 8'h0F;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] param1;
    logic [15:0] param2;
  } zrx_cmd_type;

  typedef struct packed {
    logic valid;
    logic merged;
    logic [3:0] source_slot;
    logic origin_rand;
    logic [7:0][31:0] value;
  } zrx_digest_type;

  typedef struct packed {
    logic [7:0] status;
    logic has_data;
    logic long_read;
    logic [7:0][31:0] data;
  } zrx_rsp_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_FETCH = 5'h04,
    ST_WAIT = 5'h08,
    ST_RESP = 5'h10
  } zrx_state_type;
endpackage : zrx_pkg

// file: tb/zrx_mem_model.sv
`timescale 1ns/1ns
module zrx_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Read request
  input wire logic i_rd,
  input wire logic [1:0] i_zone,
  input wire logic [7:0] i_addr,
  input wire logic i_slow,
  // Read answer
  output logic o_vld,
  output logic [31:0] o_data
);
  logic busy_q, busy_d;
  logic [1:0] cnt_q, cnt_d;
  logic [31:0] last_q, last_d;
  always_comb begin
    cnt_d = i_rd ? {i_slow, i_slow} : cnt_q - 2'(cnt_q != 2'h0);
    o_vld = busy_q && cnt_q == 2'h0;
    busy_d = (busy_q & ~o_vld) | i_rd;
    // Idle data is inverted so a stale word never matches
    o_data = o_vld ? {6'h00, i_zone, i_addr, 8'h5A, ~i_addr} : ~last_q;
    last_d = o_vld ? o_data : last_q;
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
      last_q <= 32'h00000000;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
    end
  end
endmodule : zrx_mem_model

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] S_OK = zrx_pkg::STS_OK;
  localparam logic [7:0] S_PE = zrx_pkg::STS_PARSE;
  localparam logic [7:0] S_EX = zrx_pkg::STS_EXEC;
  logic clk, rstn, cmd_valid, cmd_ready, rsp_valid, setup_l, fuse_l, data_l;
  logic mem_rd, mem_vld, slow, cfg_wr, wr_pick, wr_seen;
  logic [7:0] fuse_pol, user_b, pick_b, pick_en, wr_data, mem_addr;
  logic [1:0] mem_zone;
  logic [31:0] mem_data;
  logic [15:0][15:0] pol;
  zrx_pkg::zrx_cmd_type cmd;
  zrx_pkg::zrx_rsp_type rsp, got;
  zrx_pkg::zrx_digest_type dig, keep;
  int mismatches, num_checks, cycles;

  zrx_core zrx_core_i (
    .I_CORE_CLK(clk), .I_RESETN(rstn), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
    .O_CMD_READY(cmd_ready), .O_RSP_VALID(rsp_valid), .O_RSP(rsp),
    .I_SETUP_LOCKED(setup_l), .I_FUSE_LOCKED(fuse_l), .I_DATA_LOCKED(data_l),
    .I_FUSE_AREA_POLICY(fuse_pol), .I_SLOT_POLICY_WORD(pol), .I_SCRATCH_DIGEST_REG(dig),
    .I_SPARE_USER_BYTE(user_b), .I_PICK_BYTE(pick_b), .I_PICK_CHECK_ENABLE(pick_en),
    .O_MEM_RD(mem_rd), .O_MEM_ZONE(mem_zone), .O_MEM_ADDR(mem_addr),
    .I_MEM_VLD(mem_vld), .I_MEM_DATA(mem_data),
    .O_CFG_WR(cfg_wr), .O_CFG_WR_PICK(wr_pick), .O_CFG_WR_DATA(wr_data)
  );
  zrx_mem_model zrx_mem_model_i (
    .i_clk(clk), .i_resetn(rstn), .i_rd(mem_rd), .i_zone(mem_zone),
    .i_addr(mem_addr), .i_slow(slow), .o_vld(mem_vld), .o_data(mem_data)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step();
    @(posedge clk);
    #10;
  endtask : step

  function automatic logic [31:0] mem_word(input logic [1:0] z, input logic [15:0] a);
    return {6'h00, z, a[7:0], 8'h5A, ~a[7:0]};
  endfunction : mem_word

  task automatic exec(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2);
    int n;
    wr_seen = 1'b0;
    while (cmd_ready !== 1'b1) step();
    cmd = {op, p1, p2};
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
    n = 0;
    // Bounded so a lost response shows as a mismatch
    while (rsp_valid !== 1'b1 && n < 200) begin
      step();
      n++;
      wr_seen = wr_seen | cfg_wr;
    end
    got = rsp;
  endtask : exec

  task automatic rd(input logic [7:0] p1, input logic [15:0] a, input logic [7:0] st,
                    input logic msk);
    logic [15:0] base;
    exec(zrx_pkg::OP_READ, p1, a);
    check("status", 32'(got.status), 32'(st));
    if (st == S_OK) begin
      base = p1[7] ? (a & zrx_pkg::BLOCK_ALIGN_MASK) : a;
      check("flags", 32'({got.has_data, got.long_read}), 32'({1'b1, p1[7]}));
      for (int k = 0; k < (p1[7] ? 8 : 1); k++) begin
        check("word", got.data[k],
              mem_word(p1[1:0], base + 16'(k)) ^ (msk ? dig.value[k] : 32'h00000000));
      end
    end
  endtask : rd

  task automatic upd(input logic sel, input logic [7:0] v, input logic [7:0] st, input logic wr);
    exec(zrx_pkg::OP_UPDATE, {7'h00, sel}, {8'h00, v});
    check("upd status", 32'(got.status), 32'(st));
    check("cfg write", 32'(wr_seen), 32'(wr));
    if (wr) check("cfg data", 32'({wr_pick, wr_data}), 32'({sel, v}));
  endtask : upd

  initial begin
    {rstn, cmd_valid, cmd, slow, fuse_pol, user_b, pick_b, pick_en, pol} = '0;
    {setup_l, fuse_l, data_l} = 3'h7;
    pol[1] = 16'h0080;
    // Masked slot uses key 5; no slot is masked without hidden
    pol[2] = 16'h00C5;
    dig.valid = 1'b1;
    dig.merged = 1'b1;
    dig.source_slot = 4'h5;
    dig.origin_rand = 1'b1;
    for (int k = 0; k < 8; k++) dig.value[k] = 32'hC3A50F10 + 32'(k * 7);
    repeat (4) @(posedge clk);
    #10;
    rstn = 1'b1;
    rd(8'h00, 16'h0003, S_OK, 0);
    rd(8'h80, 16'h000B, S_OK, 0);
    rd(8'h00, 16'h0015, S_OK, 0);
    rd(8'h00, 16'h0016, S_EX, 0);
    rd(8'h80, 16'h0010, S_EX, 0);
    rd(8'h04, 16'h0000, S_PE, 0);
    rd(8'h03, 16'h0000, S_PE, 0);
    exec(8'h55, 8'h00, 16'h0000);
    check("opcode", 32'(got.status), 32'(S_PE));
    exec(zrx_pkg::OP_UPDATE, 8'h02, 16'h0000);
    check("mode", 32'(got.status), 32'(S_PE));
    exec(zrx_pkg::OP_UPDATE, 8'h00, 16'h0100);
    check("operand", 32'(got.status), 32'(S_PE));
    rd(8'h02, 16'h0001, S_OK, 0);
    rd(8'h82, 16'h0005, S_OK, 0);
    rd(8'h02, 16'h0008, S_EX, 0);
    rd(8'h82, 16'h0008, S_EX, 0);
    rd(8'h02, 16'h0010, S_EX, 0);
    slow = 1'b1;
    rd(8'h82, 16'h0013, S_OK, 1);
    slow = 1'b0;
    keep = dig;
    for (int i = 0; i < 4; i++) begin
      dig.valid = (i != 0);
      dig.merged = (i != 1);
      dig.source_slot = (i == 2) ? 4'h4 : 4'h5;
      dig.origin_rand = (i != 3);
      rd(8'h82, 16'h0010, S_EX, 1);
    end
    dig = keep;
    rd(8'h02, 16'h0080, S_EX, 0);
    data_l = 1'b0;
    rd(8'h02, 16'h0001, S_EX, 0);
    data_l = 1'b1;
    setup_l = 1'b0;
    rd(8'h00, 16'h0002, S_OK, 0);
    setup_l = 1'b1;
    fuse_l = 1'b0;
    rd(8'h01, 16'h0002, S_EX, 0);
    fuse_l = 1'b1;
    rd(8'h01, 16'h0000, S_OK, 0);
    fuse_pol = 8'h55;
    rd(8'h01, 16'h0001, S_EX, 0);
    rd(8'h01, 16'h0002, S_OK, 0);
    fuse_pol = zrx_pkg::FUSE_LEGACY;
    rd(8'h81, 16'h0008, S_EX, 0);
    rd(8'h01, 16'h000F, S_OK, 0);
    rd(8'h01, 16'h0010, S_EX, 0);
    upd(1'b0, 8'h3C, S_OK, 1);
    user_b = 8'h3C;
    upd(1'b0, 8'h11, S_EX, 0);
    pick_en = 8'h01;
    upd(1'b1, 8'h77, S_OK, 1);
    pick_b = 8'h77;
    upd(1'b1, 8'h22, S_EX, 0);
    pick_en = 8'h00;
    upd(1'b1, 8'h99, S_OK, 1);
    setup_l = 1'b0;
    user_b = 8'h00;
    upd(1'b0, 8'h01, S_EX, 0);
    complete_run();
  end
endmodule : tb_top
